// >>> common/uiic_consts.vh
// Constants for the interrupt identification and FIFO control block.
// Assumes a 32-bit register word with data in the low byte.
`ifndef UIIC_CONSTS_VH
`define UIIC_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define UIIC_OFF_HOLD 12'h000
`define UIIC_OFF_IER 12'h004
`define UIIC_OFF_IDENT 12'h008
`define UIIC_OFF_LCR 12'h00C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define UIIC_FC_TRIG_HI 7
`define UIIC_FC_TRIG_LO 6
`define UIIC_FC_DMA_MODE 3
`define UIIC_FC_TX_FLUSH 2
`define UIIC_FC_RX_FLUSH 1
`define UIIC_FC_QUEUE_EN 0
`define UIIC_LCR_DIVISOR_ACCESS 7
`define UIIC_IER_RX_DATA 0
`define UIIC_IER_TX_EMPTY 1
`define UIIC_IER_LINE 2
`define UIIC_IER_MODEM 3

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define UIIC_IDENT_RESET 8'h01
`define UIIC_FC_RESET 8'h00
`define UIIC_ID_LINE 3'h3
`define UIIC_ID_RX_DATA 3'h2
`define UIIC_ID_TIMEOUT 3'h6
`define UIIC_ID_TX_EMPTY 3'h1
`define UIIC_ID_MODEM 3'h0
`define UIIC_QUEUE_EN_CODE 2'h3
`define UIIC_TRIG_1 5'h01
`define UIIC_TRIG_4 5'h04
`define UIIC_TRIG_8 5'h08
`define UIIC_TRIG_14 5'h0E
`define UIIC_QUEUE_DEPTH 5'h10

`endif

// >>> design/uiic_prio.v
// Priority encoder for the interrupt identifier.
// Assumes the source levels are already gated by their enables.
`timescale 1ns/1ps
`default_nettype none
`include "uiic_consts.vh"

module uiic_prio (
	input wire i_line,
	input wire i_rx_data,
	input wire i_timeout,
	input wire i_tx_empty,
	input wire i_modem,
	output reg [2:0] o_code,
	output reg o_pending
);

	// ------------------------------------------------------------
	// Highest pending source wins
	// ------------------------------------------------------------
	always @* begin
		o_pending = 1'b1;
		if (i_line) begin
			o_code = `UIIC_ID_LINE;
		end else if (i_timeout) begin
			o_code = `UIIC_ID_TIMEOUT;
		end else if (i_rx_data) begin
			o_code = `UIIC_ID_RX_DATA;
		end else if (i_tx_empty) begin
			o_code = `UIIC_ID_TX_EMPTY;
		end else if (i_modem) begin
			o_code = `UIIC_ID_MODEM;
		end else begin
			o_code = `UIIC_ID_MODEM;
			o_pending = 1'b0;
		end
	end

endmodule // uiic_prio
`default_nettype wire

// >>> design/uiic_ctrl.v
// Interrupt identification, FIFO control and DMA request logic.
// Assumes the surrounding UART supplies queue levels, error flags and register strobes.
`timescale 1ns/1ps
`default_nettype none
`include "uiic_consts.vh"

module uiic_ctrl (
	input wire i_clk,
	input wire i_nrst,
	input wire [11:0] i_addr,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] i_wdata,
	output reg [31:0] o_rdata,
	input wire i_frame_err,
	input wire i_parity_err,
	input wire i_overrun_err,
	input wire i_break,
	input wire i_char_timeout,
	input wire i_tx_empty_evt,
	input wire i_modem_evt,
	input wire [4:0] i_rx_count,
	input wire [4:0] i_tx_count,
	output wire o_queue_enable,
	output wire [4:0] o_rx_trigger,
	output reg o_tx_queue_flush,
	output reg o_rx_queue_flush,
	output wire o_rx_dma_req_n,
	output wire o_tx_dma_req_n,
	output wire o_irq
);

	// ------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------
	reg rst_meta_q;
	reg rst_sync_q;
	wire rst_n;

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rst_n = rst_sync_q;

	// ------------------------------------------------------------
	// Trigger level decode
	// ------------------------------------------------------------
	function [4:0] trig_bytes;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: trig_bytes = `UIIC_TRIG_1;
				2'h1: trig_bytes = `UIIC_TRIG_4;
				2'h2: trig_bytes = `UIIC_TRIG_8;
				default: trig_bytes = `UIIC_TRIG_14;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [1:0] trig_sel_q;
	reg dma_mode_q;
	reg queue_en_q;
	reg [3:0] ier_q;
	reg divisor_access_q;
	reg line_flag_q;
	reg line_flag_d;
	reg tx_empty_flag_q;
	reg tx_empty_flag_d;
	reg modem_flag_q;
	reg modem_flag_d;
	reg tx_req_n_q;
	reg tx_req_n_d;
	reg rx_req_n_q;
	reg rx_req_n_d;
	reg [7:0] ident_q;

	wire wr_ier;
	wire wr_fc;
	wire wr_lcr;
	wire wr_hold;
	wire rd_ident;
	wire line_evt;
	wire [2:0] id_code;
	wire id_pending;
	wire rx_data_lvl;
	wire timeout_lvl;

	assign wr_ier = i_wr && (i_addr == `UIIC_OFF_IER) && !divisor_access_q;
	assign wr_lcr = i_wr && (i_addr == `UIIC_OFF_LCR);
	assign wr_fc = i_wr && (i_addr == `UIIC_OFF_IDENT);
	// Holding register write, hidden behind the divisor access bit
	assign wr_hold = i_wr && (i_addr == `UIIC_OFF_HOLD) && !divisor_access_q;
	assign rd_ident = i_rd && (i_addr == `UIIC_OFF_IDENT) && !divisor_access_q;
	assign line_evt = i_frame_err | i_parity_err | i_overrun_err | i_break;

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_sel_q <= 2'h0;
			dma_mode_q <= 1'b0;
			queue_en_q <= 1'b0;
			ier_q <= 4'h0;
			divisor_access_q <= 1'b0;
			o_tx_queue_flush <= 1'b0;
			o_rx_queue_flush <= 1'b0;
		end else begin
			o_tx_queue_flush <= 1'b0;
			o_rx_queue_flush <= 1'b0;
			if (wr_ier) begin
				ier_q <= i_wdata[3:0];
			end
			if (wr_lcr) begin
				divisor_access_q <= i_wdata[`UIIC_LCR_DIVISOR_ACCESS];
			end
			if (wr_fc) begin
				queue_en_q <= i_wdata[`UIIC_FC_QUEUE_EN];
				// Settings only take hold with queues on
				if (i_wdata[`UIIC_FC_QUEUE_EN]) begin
					trig_sel_q <= i_wdata[`UIIC_FC_TRIG_HI:`UIIC_FC_TRIG_LO];
					dma_mode_q <= i_wdata[`UIIC_FC_DMA_MODE];
				end
				o_tx_queue_flush <= i_wdata[`UIIC_FC_TX_FLUSH];
				o_rx_queue_flush <= i_wdata[`UIIC_FC_RX_FLUSH];
			end
		end
	end

	assign o_queue_enable = queue_en_q;
	assign o_rx_trigger = trig_bytes(trig_sel_q);

	// ------------------------------------------------------------
	// Interrupt sources
	// ------------------------------------------------------------
	// Sticky sources: set wins over clear
	always @* begin
		line_flag_d = line_flag_q;
		tx_empty_flag_d = tx_empty_flag_q;
		modem_flag_d = modem_flag_q;
		if (rd_ident && !ident_q[0] && (ident_q[3:1] == `UIIC_ID_LINE)) begin
			line_flag_d = 1'b0;
		end
		if (rd_ident && !ident_q[0] && (ident_q[3:1] == `UIIC_ID_TX_EMPTY)) begin
			tx_empty_flag_d = 1'b0;
		end
		if (wr_hold) begin
			tx_empty_flag_d = 1'b0;
		end
		if (line_evt) begin
			line_flag_d = 1'b1;
		end
		if (i_tx_empty_evt) begin
			tx_empty_flag_d = 1'b1;
		end
		if (i_modem_evt) begin
			modem_flag_d = 1'b1;
		end
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_flag_q <= 1'b0;
			tx_empty_flag_q <= 1'b0;
			modem_flag_q <= 1'b0;
		end else begin
			line_flag_q <= line_flag_d;
			tx_empty_flag_q <= tx_empty_flag_d;
			modem_flag_q <= modem_flag_d;
		end
	end

	assign rx_data_lvl = queue_en_q ? (i_rx_count >= o_rx_trigger) : (i_rx_count != 5'h00);
	assign timeout_lvl = queue_en_q && i_char_timeout && (i_rx_count != 5'h00);

	uiic_prio u_prio (
		.i_line(line_flag_q && ier_q[`UIIC_IER_LINE]),
		.i_rx_data(rx_data_lvl && ier_q[`UIIC_IER_RX_DATA]),
		.i_timeout(timeout_lvl && ier_q[`UIIC_IER_RX_DATA]),
		.i_tx_empty(tx_empty_flag_q && ier_q[`UIIC_IER_TX_EMPTY]),
		.i_modem(modem_flag_q && ier_q[`UIIC_IER_MODEM]),
		.o_code(id_code),
		.o_pending(id_pending)
	);

	// ------------------------------------------------------------
	// Identification register
	// ------------------------------------------------------------
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ident_q <= `UIIC_IDENT_RESET;
		end else begin
			ident_q[7:6] <= queue_en_q ? `UIIC_QUEUE_EN_CODE : 2'h0;
			ident_q[5:4] <= 2'h0;
			ident_q[3:1] <= id_code;
			ident_q[0] <= !id_pending;
		end
	end

	assign o_irq = !ident_q[0];

	// ------------------------------------------------------------
	// DMA requests
	// ------------------------------------------------------------
	always @* begin
		tx_req_n_d = tx_req_n_q;
		rx_req_n_d = rx_req_n_q;
		if (!queue_en_q || !dma_mode_q) begin
			tx_req_n_d = (i_tx_count != 5'h00);
			rx_req_n_d = (i_rx_count == 5'h00);
		end else begin
			// Mode 1 keeps the last level between thresholds
			if (i_tx_count == 5'h00) begin
				tx_req_n_d = 1'b0;
			end else if (i_tx_count == `UIIC_QUEUE_DEPTH) begin
				tx_req_n_d = 1'b1;
			end
			if (i_rx_count == 5'h00) begin
				rx_req_n_d = 1'b1;
			end else if ((i_rx_count >= o_rx_trigger) || i_char_timeout) begin
				rx_req_n_d = 1'b0;
			end
		end
	end

	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_req_n_q <= 1'b0;
			rx_req_n_q <= 1'b1;
		end else begin
			tx_req_n_q <= tx_req_n_d;
			rx_req_n_q <= rx_req_n_d;
		end
	end

	assign o_tx_dma_req_n = tx_req_n_q;
	assign o_rx_dma_req_n = rx_req_n_q;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			o_rdata <= 32'h00000000;
			case (i_addr)
				`UIIC_OFF_IDENT: begin
					if (divisor_access_q) begin
						o_rdata[7:0] <= {trig_sel_q, 2'h0, dma_mode_q, 2'h0, queue_en_q};
					end else begin
						o_rdata[7:0] <= ident_q;
					end
				end
				`UIIC_OFF_IER: begin
					o_rdata[3:0] <= divisor_access_q ? 4'h0 : ier_q;
				end
				`UIIC_OFF_LCR: begin
					o_rdata[7] <= divisor_access_q;
				end
				default: begin
					o_rdata <= 32'h00000000;
				end
			endcase
		end
	end

endmodule // uiic_ctrl
`default_nettype wire

// >>> bench/uiic_chk.sv
// Port checker for the identification and queue control block.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module uiic_chk (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [11:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] i_wdata,
	input wire logic [31:0] o_rdata,
	input wire logic [4:0] i_rx_count,
	input wire logic [4:0] i_tx_count,
	input wire logic o_queue_enable,
	input wire logic [4:0] o_rx_trigger,
	input wire logic o_tx_queue_flush,
	input wire logic o_rx_queue_flush,
	input wire logic o_rx_dma_req_n,
	input wire logic o_tx_dma_req_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	wire logic fc_wr = i_wr && i_addr == 12'h008;
	wire logic lg = !o_queue_enable && !i_wr;
	a_tx_flush_cause: assert property (fc_wr && i_wdata[2] |=> o_tx_queue_flush)
		else $error("tx flush missing");
	a_rx_flush_cause: assert property (fc_wr && i_wdata[1] |=> o_rx_queue_flush)
		else $error("rx flush missing");
	a_flush_one_cycle: assert property (o_tx_queue_flush && !fc_wr |=> !o_tx_queue_flush)
		else $error("tx flush stuck");
	a_tx_legacy_high: assert property (lg && i_tx_count != 5'h00 |=> o_tx_dma_req_n)
		else $error("tx request low with data");
	a_tx_legacy_low: assert property (lg && i_tx_count == 5'h00 |=> !o_tx_dma_req_n)
		else $error("tx request high when empty");
	a_rx_legacy_low: assert property (lg && i_rx_count != 5'h00 |=> !o_rx_dma_req_n)
		else $error("rx request high with data");
	a_rx_empty_high: assert property (!i_wr && i_rx_count == 5'h00 |=> o_rx_dma_req_n)
		else $error("rx request low when empty");
	a_trig_legal: assert property (o_rx_trigger inside {5'h01, 5'h04, 5'h08, 5'h0E})
		else $error("bad trigger level");
	a_rdata_reserved: assert property (i_rd |=> o_rdata[31:8] == 24'h000000)
		else $error("reserved read bits set");
	a_rdata_stands: assert property (!i_rd |=> $stable(o_rdata))
		else $error("read data changed");
endmodule // uiic_chk
bind uiic_ctrl uiic_chk chk_u (.i_clk, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_rx_count,
	.i_tx_count, .o_queue_enable, .o_rx_trigger, .o_tx_queue_flush, .o_rx_queue_flush, .o_rx_dma_req_n,
	.o_tx_dma_req_n);
`default_nettype wire

// >>> bench/uiic_qmodel.sv
// Queue level model standing behind the request pins.
// Assumes the bench presets levels; flush pulses empty the queues.
`timescale 1ns/1ps
`default_nettype none
module uiic_qmodel (
	input wire logic i_clk,
	input wire logic i_load,
	input wire logic [4:0] i_rx_level,
	input wire logic [4:0] i_tx_level,
	input wire logic i_tx_flush,
	input wire logic i_rx_flush,
	output var logic [4:0] o_rx_count,
	output var logic [4:0] o_tx_count
);
	initial begin
		o_rx_count = 5'h00;
		o_tx_count = 5'h00;
	end
	always @(posedge i_clk) begin
		if (i_load) begin
			o_rx_count <= i_rx_level;
			o_tx_count <= i_tx_level;
		end
		if (i_tx_flush) o_tx_count <= 5'h00;
		if (i_rx_flush) o_rx_count <= 5'h00;
	end
endmodule // uiic_qmodel
`default_nettype wire

// >>> bench/uiic_ctrl_tb.sv
// Self-checking bench for the identification and queue control block.
// Assumes the queue model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module uiic_ctrl_tb;
	logic i_clk, i_nrst, i_wr, i_rd, i_char_timeout;
	logic i_frame_err, i_parity_err, i_overrun_err, i_break, i_tx_empty_evt, i_modem_evt;
	logic [11:0] i_addr;
	logic [31:0] i_wdata, o_rdata;
	logic [4:0] i_rx_count, i_tx_count, o_rx_trigger;
	logic o_queue_enable, o_tx_queue_flush, o_rx_queue_flush, o_rx_dma_req_n, o_tx_dma_req_n, o_irq;
	logic q_ld;
	logic [4:0] q_rx, q_tx;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	uiic_ctrl dut_u (.i_clk, .i_nrst, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_frame_err, .i_parity_err,
		.i_overrun_err, .i_break, .i_char_timeout, .i_tx_empty_evt, .i_modem_evt, .i_rx_count, .i_tx_count,
		.o_queue_enable, .o_rx_trigger, .o_tx_queue_flush, .o_rx_queue_flush, .o_rx_dma_req_n,
		.o_tx_dma_req_n, .o_irq);
	uiic_qmodel q_u (.i_clk(i_clk), .i_load(q_ld), .i_rx_level(q_rx), .i_tx_level(q_tx),
		.i_tx_flush(o_tx_queue_flush), .i_rx_flush(o_rx_queue_flush),
		.o_rx_count(i_rx_count), .o_tx_count(i_tx_count));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_addr = a;
		i_wdata = {24'h000000, d};
		i_wr = 1'b1;
		@(negedge i_clk);
		i_wr = 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_addr = a;
		i_rd = 1'b1;
		@(negedge i_clk);
		i_rd = 1'b0;
		chk("rdata", {24'h000000, e}, o_rdata);
	endtask
	task automatic cnt(input logic [4:0] rx, input logic [4:0] tx);
		@(negedge i_clk);
		q_rx = rx;
		q_tx = tx;
		q_ld = 1'b1;
		@(negedge i_clk);
		q_ld = 1'b0;
		@(negedge i_clk);
	endtask
	task automatic pulse(input logic [5:0] v);
		@(negedge i_clk);
		{i_modem_evt, i_tx_empty_evt, i_break, i_overrun_err, i_parity_err, i_frame_err} = v;
		@(negedge i_clk);
		{i_modem_evt, i_tx_empty_evt, i_break, i_overrun_err, i_parity_err, i_frame_err} = 6'h00;
		@(negedge i_clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_legacy;
		rdc(12'h008, 8'h01);
		chk("irq", 0, o_irq);
		cnt(5'h00, 5'h01);
		chk("txn", 1, o_tx_dma_req_n);
		cnt(5'h01, 5'h00);
		chk("rxn", 0, o_rx_dma_req_n);
		chk("txn", 0, o_tx_dma_req_n);
		cnt(5'h00, 5'h00);
		chk("rxn", 1, o_rx_dma_req_n);
		wr(12'h008, 8'hC8);
		chk("trig", 1, o_rx_trigger);
		rdc(12'h008, 8'h01);
	endtask
	task automatic t_enable;
		logic [4:0] tl[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
		cnt(5'h03, 5'h03);
		wr(12'h008, 8'h07);
		chk("txf", 1, o_tx_queue_flush);
		chk("rxf", 1, o_rx_queue_flush);
		@(negedge i_clk);
		chk("txf", 0, o_tx_queue_flush);
		chk("rxc", 0, i_rx_count);
		chk("qen", 1, o_queue_enable);
		rdc(12'h008, 8'hC1);
		for (int i = 0; i < 4; i++) begin
			wr(12'h008, {i[1:0], 6'h01});
			chk("trig", tl[i], o_rx_trigger);
		end
	endtask
	task automatic t_irq;
		wr(12'h008, 8'h01);
		wr(12'h004, 8'h0F);
		pulse(6'h20);
		rdc(12'h008, 8'hC0);
		chk("irq", 1, o_irq);
		pulse(6'h10);
		rdc(12'h008, 8'hC2);
		pulse(6'h10);
		wr(12'h000, 8'h55);
		rdc(12'h008, 8'hC0);
		cnt(5'h01, 5'h00);
		rdc(12'h008, 8'hC4);
		chk("rxn", 0, o_rx_dma_req_n);
		chk("txn", 0, o_tx_dma_req_n);
		i_char_timeout = 1'b1;
		rdc(12'h008, 8'hCC);
		for (int i = 0; i < 4; i++) begin
			pulse(6'h01 << i);
			rdc(12'h008, 8'hC6);
			rdc(12'h008, 8'hCC);
		end
		i_char_timeout = 1'b0;
		cnt(5'h00, 5'h00);
		chk("rxn", 1, o_rx_dma_req_n);
		wr(12'h004, 8'h00);
		rdc(12'h008, 8'hC1);
		chk("irq", 0, o_irq);
	endtask
	task automatic t_mode1;
		wr(12'h008, 8'h49);
		cnt(5'h03, 5'h00);
		chk("txn", 0, o_tx_dma_req_n);
		chk("rxn", 1, o_rx_dma_req_n);
		cnt(5'h04, 5'h05);
		chk("txn", 0, o_tx_dma_req_n);
		chk("rxn", 0, o_rx_dma_req_n);
		cnt(5'h02, 5'h10);
		chk("txn", 1, o_tx_dma_req_n);
		chk("rxn", 0, o_rx_dma_req_n);
		cnt(5'h00, 5'h05);
		chk("txn", 1, o_tx_dma_req_n);
		chk("rxn", 1, o_rx_dma_req_n);
		i_char_timeout = 1'b1;
		cnt(5'h01, 5'h00);
		chk("rxn", 0, o_rx_dma_req_n);
		i_char_timeout = 1'b0;
		cnt(5'h00, 5'h00);
	endtask
	task automatic t_readback;
		wr(12'h00C, 8'h80);
		rdc(12'h008, 8'h49);
		rdc(12'h004, 8'h00);
		wr(12'h00C, 8'h00);
		rdc(12'h008, 8'hC1);
		rdc(12'h01C, 8'h00);
	endtask
	initial begin
		{i_nrst, i_wr, i_rd, i_char_timeout, i_addr, i_wdata} = '0;
		{q_ld, q_rx, q_tx} = '0;
		{i_modem_evt, i_tx_empty_evt, i_break, i_overrun_err, i_parity_err, i_frame_err} = 6'h00;
		repeat (8) @(negedge i_clk);
		i_nrst = 1'b1;
		repeat (4) @(negedge i_clk);
		t_legacy();
		t_enable();
		t_irq();
		t_mode1();
		t_readback();
		stop_test();
	end
endmodule // uiic_ctrl_tb
`default_nettype wire
